/* File: ext_decode.sv */
/*
 Extended instruction decoder and execute unit with an APB register
 file. Software writes operands and opcode words; extension words
 prefix the next word, which is decoded and executed at once.
 Assumes an APB3 master on pclk; no wait states are inserted.
*/
`timescale 1ns/10ps
`include "ext_decode_defs.svh"

module ext_decode (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire ext_decode_pkg::apb_req_t apb_i,
   output ext_decode_pkg::apb_rsp_t apb_o
);
   import ext_decode_pkg::*;

   state_t q;
   state_t q_nxt;

   wire wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
   wire setup = apb_i.psel & ~apb_i.penable;
   wire op_wr = wr & (apb_i.paddr == `OFF_OP);
   wire [15:0] pw = apb_i.pwdata[15:0];
   wire pre_q = (q.st == ST_PREFIXED);
   wire [3:0] nib_sel = q.nib[q.ext[3:0]];

   // Zero wait states; error captured during setup
   assign apb_o.pready = 1'b1;
   assign apb_o.pslverr = q.err;
   assign apb_o.prdata = q.rdata;

   function automatic logic is_ext(input logic [15:0] w);
      is_ext = (w[15:11] == `EXT_OPC);
   endfunction

   // Register mode: both operands registers, or single register
   function automatic logic regmode(input logic [15:0] w);
      if (w[15:12] >= 4'h4) begin
         regmode = ~w[7] & (w[5:4] == 2'h0);
      end else begin
         regmode = (w[5:4] == 2'h0);
      end
   endfunction

   function automatic logic [19:0] szmask(input size_t s);
      case (s)
         SZ_B8: szmask = 20'h000ff;
         SZ_W16: szmask = 20'h0ffff;
         default: szmask = 20'hfffff;
      endcase
   endfunction

   function automatic logic [19:0] topbit(input size_t s);
      case (s)
         SZ_B8: topbit = 20'h00080;
         SZ_W16: topbit = 20'h08000;
         default: topbit = 20'h80000;
      endcase
   endfunction

   // Constant generator registers stand in for emulated operands
   function automatic logic [19:0] cgen(input logic [3:0] rg, input logic [1:0] as,
                                        input logic [19:0] v);
      cgen = v;
      if (rg == 4'h3) begin
         case (as)
            2'h0: cgen = 20'h00000;
            2'h1: cgen = 20'h00001;
            2'h2: cgen = 20'h00002;
            default: cgen = 20'hfffff;
         endcase
      end else if (rg == 4'h2 && as[1]) begin
         cgen = as[0] ? 20'h00008 : 20'h00004;
      end
   endfunction

   // Binary add at size s; returns {carry, overflow, result}
   function automatic logic [21:0] addsub(input logic [19:0] d, input logic [19:0] a,
                                          input logic ci, input size_t s);
      logic [20:0] sum;
      logic [19:0] m;
      logic [19:0] hb;
      logic [19:0] r;
      m = szmask(s);
      hb = topbit(s);
      sum = {1'b0, d & m} + {1'b0, a & m} + {20'h00000, ci};
      r = sum[19:0] & m;
      addsub = {|(sum & {hb, 1'b0}), (|(a & hb) == |(d & hb)) && (|(r & hb) != |(d & hb)), r};
   endfunction

   // Decimal add nibble by nibble; returns {carry, result}
   function automatic logic [20:0] bcd_add(input logic [19:0] a, input logic [19:0] b,
                                           input logic ci, input size_t s);
      logic [4:0] t;
      logic c;
      logic [19:0] r;
      logic [4:0] cy;
      c = ci;
      r = 20'h00000;
      cy = 5'h00;
      for (int i = 0; i < 5; i++) begin
         t = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
         if (t > 5'h09) begin
            t = t + 5'h06;
         end
         r[4*i+:4] = t[3:0];
         c = t[4] | (t > 5'h09);
         cy[i] = c;
      end
      case (s)
         SZ_B8: bcd_add = {cy[1], r & 20'h000ff};
         SZ_W16: bcd_add = {cy[3], r & 20'h0ffff};
         default: bcd_add = {cy[4], r};
      endcase
   endfunction

   // Bus access, decode and execute in one next-state process
   always_comb begin
      logic [15:0] w;
      logic rm;
      logic cin;
      logic upd;
      logic tb;
      logic [1:0] cnt;
      size_t s;
      logic [19:0] m;
      logic [19:0] hb;
      logic [19:0] sv;
      logic [19:0] dv;
      logic [19:0] a;
      logic [19:0] r;
      logic [21:0] ar;
      flags_t f;
      dec_t dc;
      w = pw;
      rm = 1'b0;
      cin = 1'b0;
      upd = 1'b0;
      tb = 1'b0;
      cnt = 2'h0;
      s = SZ_W16;
      m = 20'h0ffff;
      hb = 20'h08000;
      sv = q.src;
      dv = q.dst;
      a = q.src;
      r = q.res;
      ar = 22'h000000;
      f = q.fl;
      dc = '0;
      q_nxt = q;
      if (setup) begin
         q_nxt.err = 1'b0;
         case (apb_i.paddr)
            `OFF_OP: q_nxt.rdata = {16'h0000, q.ext};
            `OFF_SRC: q_nxt.rdata = {12'h000, q.src};
            `OFF_DST: q_nxt.rdata = {12'h000, q.dst};
            `OFF_FLAGS: q_nxt.rdata = {28'h0000000, q.fl};
            `OFF_NIB: q_nxt.rdata = 32'h00000000;
            `OFF_RES: q_nxt.rdata = {12'h000, q.res};
            `OFF_STAT: q_nxt.rdata = {9'h000, pre_q, q.dec};
            default: begin
               q_nxt.rdata = 32'h00000000;
               q_nxt.err = 1'b1;
            end
         endcase
      end
      if (wr) begin
         case (apb_i.paddr)
            `OFF_SRC: q_nxt.src = apb_i.pwdata[19:0];
            `OFF_DST: q_nxt.dst = apb_i.pwdata[19:0];
            `OFF_FLAGS: q_nxt.fl = apb_i.pwdata[3:0];
            `OFF_NIB: q_nxt.nib[apb_i.pwdata[11:8]] = apb_i.pwdata[3:0];
            default: ;
         endcase
      end
      if (op_wr && is_ext(w)) begin
         q_nxt.ext = w;
         q_nxt.st = ST_PREFIXED;
      end else if (op_wr) begin
         rm = regmode(w);
         cin = q.fl.c & ~(pre_q & rm & q.ext[`EXT_ZC]);
         dc.zc = pre_q & rm & q.ext[`EXT_ZC];
         if (pre_q && rm) begin
            dc.rpt = q.ext[`EXT_RPT] ? nib_sel : q.ext[3:0];
         end
         if (pre_q && !rm) begin
            dc.shi = q.ext[10:7];
            dc.dhi = q.ext[3:0];
         end
         // Size from prefix, else plain byte or word
         if (w[15:10] == 6'h04 && !w[9] && w[7]) begin
            s = !pre_q ? SZ_W16 : w[6] ? SZ_RSVD : q.ext[`EXT_AL] ? SZ_W16 : SZ_A20;
         end else begin
            s = pre_q ? size_t'({q.ext[`EXT_AL], w[6]}) : (w[6] ? SZ_B8 : SZ_W16);
         end
         dc.swords = 2'h1;
         dc.dwords = 2'h1;
         if (w[15:12] >= 4'h4) begin
            m = szmask(s);
            hb = topbit(s);
            sv = cgen(w[11:8], w[5:4], q.src);
            if (pre_q && !rm && w[5:4] == 2'h3 && w[11:8] == 4'h0) begin
               sv = {dc.shi, q.src[15:0]};
            end
            // Wide operand held in memory costs two words; constants never do
            if (s == SZ_A20 && w[5:4] != 2'h0 && w[11:8] != 4'h3 &&
                !(w[11:8] == 4'h2 && w[5])) begin
               dc.swords = 2'h2;
            end
            if (s == SZ_A20 && w[7]) begin
               dc.dwords = 2'h2;
            end
            a = (w[15:12] >= 4'h7 && w[15:12] <= 4'h9) ? ~sv : sv;
            tb = (w[15:12] == 4'h5) ? 1'b0 : (w[15:12] == 4'h6 || w[15:12] == 4'h7) ? cin : 1'b1;
            ar = addsub(dv, a, tb, s);
            dc.wb = 1'b1;
            case (w[15:12])
               4'h4: r = sv & m;
               4'h5, 4'h6, 4'h7, 4'h8, 4'h9: begin
                  r = ar[19:0];
                  f.c = ar[21];
                  f.v = ar[20];
                  upd = 1'b1;
                  dc.wb = (w[15:12] != 4'h9);
               end
               4'ha: begin
                  {f.c, r} = bcd_add(sv, dv, cin, s);
                  f.v = 1'b0;
                  upd = 1'b1;
               end
               4'hb, 4'hf: begin
                  r = sv & dv & m;
                  f.v = 1'b0;
                  f.c = |r;
                  upd = 1'b1;
                  dc.wb = (w[15:12] == 4'hf);
               end
               4'hc: r = ~sv & dv & m;
               4'hd: r = (sv | dv) & m;
               default: begin
                  r = (sv ^ dv) & m;
                  f.v = |(sv & hb) & |(dv & hb);
                  f.c = |r;
                  upd = 1'b1;
               end
            endcase
         end else if (w[15:10] == 6'h04) begin
            m = szmask(s);
            hb = topbit(s);
            if (s == SZ_A20 && w[5:4] != 2'h0) begin
               dc.dwords = 2'h2;
            end
            dc.wb = 1'b1;
            if (w[9:8] == 2'h3 && w[7:4] >= 4'h4 && w[7:4] != 4'ha && w[7:4] <= 4'hb) begin
               r = w[7] ? {w[3:0], q.dst[15:0]} : q.dst;
               dc.branch = 1'b1;
               s = SZ_A20;
            end else begin
               case (w[9:7])
                  3'h0: begin
                     r = ((dv & m) >> 1) | (cin ? hb : 20'h00000);
                     f.c = dv[0];
                     f.v = 1'b0;
                     upd = 1'b1;
                  end
                  3'h2: begin
                     r = ((dv & m) >> 1) | (dv & hb);
                     f.c = dv[0];
                     f.v = 1'b0;
                     upd = 1'b1;
                  end
                  3'h1: r = {dv[19:16] & m[19:16], dv[7:0], dv[15:8]};
                  3'h3: begin
                     r = dv[7] ? ((m & 20'hfff00) | {12'h000, dv[7:0]}) : {12'h000, dv[7:0]};
                     f.v = 1'b0;
                     f.c = |r;
                     upd = 1'b1;
                  end
                  default: r = dv & m;
               endcase
            end
         end else if (w[15:10] == 6'h05) begin
            s = w[8] ? SZ_W16 : SZ_A20;
            dc.rpt = w[7:4];
         end else if (w[7:5] == 3'h2) begin
            // Multi-bit rotate on a register, no prefix needed
            s = w[4] ? SZ_W16 : SZ_A20;
            m = szmask(s);
            hb = topbit(s);
            cnt = w[11:10];
            dc.rpt = {2'h0, cnt};
            r = dv & m;
            for (int i = 0; i < 4; i++) begin
               if (i <= int'(cnt)) begin
                  case (w[9:8])
                     2'h0: tb = r[0];
                     2'h1: tb = r[0];
                     2'h2: tb = |(r & hb);
                     default: tb = r[0];
                  endcase
                  case (w[9:8])
                     2'h0: r = (r >> 1) | (f.c ? hb : 20'h00000);
                     2'h1: r = (r >> 1) | (r & hb);
                     2'h2: r = (r << 1) & m;
                     default: r = r >> 1;
                  endcase
                  f.c = tb;
               end
            end
            f.v = (w[9:8] == 2'h2) && (|(dv & hb) != |(r & hb));
            upd = 1'b1;
            dc.wb = 1'b1;
         end else begin
            // Address operations: always 20-bit, never prefixed
            s = SZ_A20;
            dc.bad = pre_q;
            dc.wb = 1'b1;
            sv = w[6] ? q.src : {w[11:8], q.src[15:0]};
            if (w[7] && w[5:4] != 2'h0) begin
               a = (w[5:4] == 2'h2) ? sv : ~sv;
               ar = addsub(dv, a, w[5:4] != 2'h2, s);
               r = ar[19:0];
               f.c = ar[21];
               f.v = ar[20];
               upd = 1'b1;
               dc.wb = (w[5:4] != 2'h1);
            end else begin
               r = w[7] ? sv : q.src;
               dc.dwords = (w[7:4] == 4'h6 || w[7:4] == 4'h7) ? 2'h2 : 2'h1;
            end
         end
         if (upd) begin
            f.n = |(r & topbit(s));
            f.z = ~|(r & szmask(s));
         end
         dc.sz = s;
         if (s == SZ_RSVD) begin
            dc.bad = 1'b1;
         end
         if (!dc.bad) begin
            q_nxt.res = r;
            q_nxt.fl = f;
         end
         q_nxt.dec = dc;
         q_nxt.st = ST_PLAIN;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{st: ST_PLAIN, fl: `FLAGS_RST, src: `SRC_RST, default: '0};
      end else begin
         q <= q_nxt;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ext_capture: assert property (op_wr && is_ext(pw) |=> pre_q && q.ext == $past(pw))
      else $error("extension word not held");
   a_prefix_once: assert property (op_wr && !is_ext(pw) |=> !pre_q)
      else $error("prefix outlived its instruction");
   a_rpt_field: assert property (op_wr && pre_q && !is_ext(pw) && pw[15:12] >= 4'h4 &&
         regmode(pw) && !q.ext[7] |=> q.dec.rpt == $past(q.ext[3:0]))
      else $error("repeat count not from extension word");
   a_rpt_reg: assert property (op_wr && pre_q && !is_ext(pw) && pw[15:12] >= 4'h4 &&
         regmode(pw) && q.ext[7] |=> q.dec.rpt == $past(nib_sel))
      else $error("repeat count not from register");
   a_size_pick: assert property (op_wr && pre_q && pw[15:12] >= 4'h4 |=>
         q.dec.sz == size_t'({$past(q.ext[6]), $past(pw[6])}))
      else $error("operand size wrong");
   a_src_high: assert property (op_wr && pre_q && pw[15:12] >= 4'h4 && !regmode(pw) |=>
         q.dec.shi == $past(q.ext[10:7]))
      else $error("source high nibble wrong");
   a_dst_high: assert property (op_wr && pre_q && pw[15:12] >= 4'h4 && !regmode(pw) |=>
         q.dec.dhi == $past(q.ext[3:0]))
      else $error("destination high nibble wrong");
   a_sub_result: assert property (op_wr && !pre_q && pw[15:12] == 4'h8 && pw[6:4] == 3'h0 &&
         pw[11:8] > 4'h3 |=> q.res == (($past(q.dst) - $past(q.src)) & 20'h0ffff))
      else $error("subtract result wrong");
   a_flags_kept: assert property (op_wr && (pw[15:12] == 4'h4 || pw[15:12] == 4'hc ||
         pw[15:12] == 4'hd) |=> q.fl == $past(q.fl))
      else $error("move or bit ops changed flags");
   a_and_carry: assert property (op_wr && !is_ext(pw) && pw[15:12] == 4'hf |=>
         q.dec.bad || (q.fl.c == !q.fl.z && !q.fl.v))
      else $error("and flags wrong");

   c_prefixed_exec: cover property (op_wr && is_ext(pw) ##1 op_wr && !is_ext(pw));
   c_multi_rotate: cover property (op_wr && pw[15:12] == 4'h0 && pw[7:5] == 3'h2);
   c_wide_call: cover property (op_wr && pw[15:8] == 8'h13 ##1 q.dec.branch);
   c_bus_error: cover property (apb_i.psel && apb_i.penable && apb_o.pslverr);

endmodule // ext_decode

/* File: ext_decode_defs.svh */
/*
 Register offsets, extension word field positions and reset values
 for the extended instruction decoder. Assumes an APB slave with an
 8-bit byte address and 32-bit data.
*/
`ifndef EXT_DECODE_DEFS_SVH
`define EXT_DECODE_DEFS_SVH

// Register byte offsets
`define OFF_OP 8'h00
`define OFF_SRC 8'h04
`define OFF_DST 8'h08
`define OFF_FLAGS 8'h0c
`define OFF_NIB 8'h10
`define OFF_RES 8'h14
`define OFF_STAT 8'h18

// Extension word layout
`define EXT_OPC 5'h03
`define EXT_ZC 8
`define EXT_RPT 7
`define EXT_AL 6

// Reset values
`define FLAGS_RST 4'h0
`define SRC_RST 20'h00000

`endif

/* File: ext_decode_pkg.sv */
/*
 Types for the extended instruction decoder: bus carriers, operand
 size, decoder state and the packed state of the whole block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ext_decode_pkg;

   // APB request from master, answer to master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   // Encoded as {length bit, byte-word bit}
   typedef enum logic [1:0] {
      SZ_RSVD = 2'h0,
      SZ_A20 = 2'h1,
      SZ_W16 = 2'h2,
      SZ_B8 = 2'h3
   } size_t;

   typedef enum logic [1:0] {
      ST_PLAIN = 2'h1,
      ST_PREFIXED = 2'h2
   } dec_st_t;

   typedef struct packed {
      logic v;
      logic n;
      logic z;
      logic c;
   } flags_t;

   // Decode summary, read back as the status register
   typedef struct packed {
      logic branch;
      logic [1:0] dwords;
      logic [1:0] swords;
      logic [3:0] dhi;
      logic [3:0] shi;
      logic [3:0] rpt;
      size_t sz;
      logic zc;
      logic wb;
      logic bad;
   } dec_t;

   typedef struct packed {
      dec_st_t st;
      logic [15:0] ext;
      logic [19:0] src;
      logic [19:0] dst;
      logic [19:0] res;
      flags_t fl;
      logic [15:0][3:0] nib;
      dec_t dec;
      logic [31:0] rdata;
      logic err;
   } state_t;

endpackage

/* File: fetch_path_model.sv */
/*
 Fetch path stand-in: an APB master that turns one command pulse into
 one complete transfer. Assumes a zero or more wait state slave on pclk.
*/
`timescale 1ns/10ps

module fetch_path_model (
   // Clock and command from the bench
   input wire logic pclk,
   input wire logic start,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   // APB master side
   output ext_decode_pkg::apb_req_t apb,
   input wire ext_decode_pkg::apb_rsp_t rsp,
   // Outcome of the transfer
   output logic done,
   output logic [31:0] rdata,
   output logic err
);
   import ext_decode_pkg::*;

   // Idle bus at time zero
   initial begin
      apb = '0;
      done = 1'b0;
      rdata = '0;
      err = 1'b0;
   end

   // Setup, then access held until pready; released address and data lines are inverted
   // so a slave that samples late never sees the old value by luck
   always @(posedge pclk) begin
      done <= apb.penable && (rsp.pready === 1'b1);
      if (!apb.psel && start && !done) begin
         apb.psel <= 1'b1;
         apb.pwrite <= wr;
         apb.paddr <= addr;
         apb.pwdata <= wdata;
      end else if (apb.psel && !apb.penable) begin
         apb.penable <= 1'b1;
      end else if (apb.penable && rsp.pready === 1'b1) begin
         rdata <= rsp.prdata;
         err <= rsp.pslverr;
         apb.psel <= 1'b0;
         apb.penable <= 1'b0;
         apb.paddr <= ~apb.paddr;
         apb.pwdata <= ~apb.pwdata;
      end
   end
endmodule // fetch_path_model

/* File: tb.sv */
/*
 Self-checking bench for the extended decoder: a table of plain and prefixed
 operations, then reset, status fields and awkward cases by hand.
 Assumes the fetch path model as the only APB master.
*/
`timescale 1ns/10ps

module tb;
   import ext_decode_pkg::*;

   typedef struct packed {
      logic [15:0] ext;
      logic [15:0] op;
      logic [19:0] src;
      logic [19:0] dst;
      logic [3:0] fi;
      logic [19:0] res;
      logic [3:0] fo;
      logic cr;
   } row_t;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic start = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic done;
   logic err;
   logic [31:0] rdata;
   logic [31:0] rv;
   apb_req_t req;
   apb_rsp_t rsp;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   row_t rows [21];

   // 20 MHz clock
   always #25 pclk = ~pclk;

   fetch_path_model u_fetch (.pclk(pclk), .start(start), .wr(wr), .addr(addr),
      .wdata(wdata), .apb(req), .rsp(rsp), .done(done), .rdata(rdata), .err(err));
   ext_decode u_dut (.pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp));

   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Hang guard, far above the fewer than nine hundred cycles the run needs
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         wrap_up;
      end
   end

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One transfer; read data lands in rv
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      start <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge pclk);
      start <= 1'b0;
      do begin
         @(posedge pclk);
         #1;
         k++;
      end while (done !== 1'b1 && k < 20);
      rv = rdata;
      chk("bus answer", 32'h1, {31'h0, done});
   endtask

   // Operands first, then optional prefix, then the opcode word
   task run(input logic [15:0] e, input logic [15:0] o, input logic [19:0] s,
            input logic [19:0] d, input logic [3:0] f);
      bus(1'b1, 8'h04, {12'h0, s});
      bus(1'b1, 8'h08, {12'h0, d});
      bus(1'b1, 8'h0c, {28'h0, f});
      if (e != 16'h0) bus(1'b1, 8'h00, {16'h0, e});
      bus(1'b1, 8'h00, {16'h0, o});
   endtask

   task stat(input logic [31:0] m, input logic [31:0] v);
      bus(1'b0, 8'h18, 32'h0);
      chk("status", v, rv & m);
   endtask

   initial begin
      rows = '{
         '{16'h1803, 16'h8445, 20'h00001, 20'h00000, 4'h0, 20'hfffff, 4'h4, 1'b1},
         '{16'h1940, 16'h7405, 20'h00001, 20'h00005, 4'h1, 20'h00003, 4'h1, 1'b1},
         '{16'h1840, 16'h9445, 20'h00005, 20'h00005, 4'h0, 20'h0, 4'h3, 1'b0},
         '{16'h1800, 16'hf445, 20'hf0f0f, 20'hff00f, 4'h0, 20'hf000f, 4'h5, 1'b1},
         '{16'h1840, 16'hb405, 20'h000f0, 20'h0000f, 4'h9, 20'h0, 4'h2, 1'b0},
         '{16'h1840, 16'he405, 20'h08000, 20'h08001, 4'h0, 20'h00001, 4'h9, 1'b1},
         '{16'h1800, 16'hc445, 20'h0000f, 20'hfffff, 4'ha, 20'hffff0, 4'ha, 1'b1},
         '{16'h1840, 16'hd445, 20'h00001, 20'h00080, 4'h5, 20'h00081, 4'h5, 1'b1},
         '{16'h1800, 16'h4445, 20'habcde, 20'h00000, 4'hf, 20'habcde, 4'hf, 1'b1},
         '{16'h1800, 16'h5445, 20'hfffff, 20'h00001, 4'h0, 20'h00000, 4'h3, 1'b1},
         '{16'h1840, 16'h6405, 20'h07fff, 20'h00000, 4'h1, 20'h08000, 4'hc, 1'b1},
         '{16'h1840, 16'ha405, 20'h00019, 20'h00001, 4'h0, 20'h00020, 4'h0, 1'b1},
         '{16'h1840, 16'h8315, 20'h00000, 20'h00005, 4'h0, 20'h00004, 4'h1, 1'b1},
         '{16'h1840, 16'h1085, 20'h01234, 20'h01234, 4'h6, 20'h03412, 4'h6, 1'b1},
         '{16'h1840, 16'h1185, 20'h00080, 20'h00080, 4'h0, 20'h0ff80, 4'h5, 1'b1},
         '{16'h0000, 16'h0f55, 20'h0000f, 20'h0000f, 4'h0, 20'h00000, 4'h3, 1'b1},
         '{16'h0000, 16'h0a85, 20'h01234, 20'h00000, 4'h9, 20'ha1234, 4'h9, 1'b1},
         '{16'h1800, 16'h1185, 20'h00080, 20'h00080, 4'h0, 20'hfff80, 4'h5, 1'b1},
         '{16'h0000, 16'h8405, 20'h00002, 20'h00007, 4'h0, 20'h00005, 4'h1, 1'b1},
         '{16'h1840, 16'h1005, 20'h00000, 20'h00003, 4'h1, 20'h08001, 4'h5, 1'b1},
         '{16'h0000, 16'h0255, 20'h00000, 20'h04001, 4'h0, 20'h08002, 4'hc, 1'b1}};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Cleared registers, and one unmapped place at the end
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         chk("reset read", 32'h0, rv);
         chk("slave error", {31'h0, i == 7}, {31'h0, err});
      end
      $display("test reset done");
      // Table of operations: result and flags
      for (int i = 0; i < 21; i++) begin
         run(rows[i].ext, rows[i].op, rows[i].src, rows[i].dst, rows[i].fi);
         bus(1'b0, 8'h14, 32'h0);
         if (rows[i].cr) chk("result", {12'h0, rows[i].res}, rv);
         bus(1'b0, 8'h0c, 32'h0);
         chk("flags", {28'h0, rows[i].fo}, rv);
      end
      $display("test table done");
      // Count, size, and prefix lifetime
      run(16'h1847, 16'h4405, 20'h1, 20'h5, 4'h0);
      stat(32'h4001ff, 32'hf2);
      run(16'h1940, 16'h7405, 20'h1, 20'h5, 4'h1);
      run(16'h0000, 16'h7405, 20'h1, 20'h5, 4'h1);
      bus(1'b0, 8'h14, 32'h0);
      chk("plain result", 32'h4, rv);
      stat(32'h400004, 32'h0);
      bus(1'b1, 8'h10, 32'h60a);
      run(16'h1886, 16'h4405, 20'h1, 20'h5, 4'h0);
      stat(32'h1e0, 32'h140);
      $display("test repeat done");
      // Top of the prefix range, replaced by a non-register prefix
      bus(1'b1, 8'h00, 32'h1fff);
      stat(32'h400000, 32'h400000);
      bus(1'b0, 8'h00, 32'h0);
      chk("ext word", 32'h1fff, rv);
      run(16'h1d05, 16'h40f5, 20'h01234, 20'h0, 4'h0);
      bus(1'b0, 8'h14, 32'h0);
      chk("wide source", 32'ha1234, rv);
      stat(32'h1ffe18, 32'h14b408);
      // Reserved size and a prefixed address op leave the result alone
      run(16'h1800, 16'h4405, 20'h55555, 20'h0, 4'h0);
      stat(32'h1, 32'h1);
      run(16'h1840, 16'h0a85, 20'h0, 20'h0, 4'h0);
      stat(32'h1, 32'h1);
      bus(1'b0, 8'h14, 32'h0);
      chk("kept result", 32'ha1234, rv);
      $display("test non-register done");
      // Push of sixteen and the wide call keep flags
      run(16'h0000, 16'h15f5, 20'h0, 20'h0, 4'hb);
      stat(32'h1e0, 32'h1e0);
      bus(1'b0, 8'h0c, 32'h0);
      chk("push flags", 32'hb, rv);
      run(16'h0000, 16'h1345, 20'h12345, 20'h12345, 4'h6);
      stat(32'h200000, 32'h200000);
      bus(1'b0, 8'h0c, 32'h0);
      chk("call flags", 32'h6, rv);
      $display("test multi done");
      // Reset in mid-run, then a write to a read-only place
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, 8'h0c, 32'h0);
      chk("flags after reset", 32'h0, rv);
      stat(32'hffffffff, 32'h0);
      bus(1'b1, 8'h14, 32'hfffff);
      chk("read-only error", 32'h0, {31'h0, err});
      bus(1'b0, 8'h14, 32'h0);
      chk("read-only write", 32'h0, rv);
      $display("test second reset done");
      wrap_up;
   end
endmodule // tb
